// >>> core/kwdt_map.vh
`ifndef KWDT_MAP_VH
`define KWDT_MAP_VH

// Register byte offsets on the APB bus
`define KWDT_OFS_KEY      12'h000
`define KWDT_OFS_STATE    12'h004
`define KWDT_OFS_IRQ_STAT 12'h008
`define KWDT_OFS_IRQ_MASK 12'h00c
`define KWDT_OFS_OVF_CNT  12'h010
`define KWDT_OFS_LAST_KEY 12'h014

// State register fields
`define KWDT_ST_CNT_LSB   0
`define KWDT_ST_CNT_MSB   8
`define KWDT_ST_RUN       9
`define KWDT_ST_PTR       10
`define KWDT_ST_ARMED     11

// Interrupt status and mask fields
`define KWDT_IRQ_OVF      0
`define KWDT_IRQ_REJECT   1
`define KWDT_IRQ_START    2
`define KWDT_IRQ_CLEAR    3
`define KWDT_IRQ_W        4

// Reset values
`define KWDT_RST_CNT      9'h000
`define KWDT_RST_MASK     4'h0
`define KWDT_RST_OVF_CNT  8'h00

// Key values and counter shape
`define KWDT_KEY_FIRST    4'h5
`define KWDT_KEY_SECOND   4'ha
`define KWDT_KEY_W        4
`define KWDT_CNT_W        9
`define KWDT_CNT_MAX      9'h1ff
`define KWDT_OVF_CNT_W    8
`define KWDT_OVF_CNT_MAX  8'hff

// Timing: bus clock and the counting tick
`define KWDT_PCLK_HZ      10000000
`define KWDT_TICK_HZ      256
// 10 MHz over 256 Hz, truncated, sized to the divider
`define KWDT_TICK_CYC     16'h9896
`define KWDT_DIV_W        16

`endif

// >>> core/kwdt_tbdiv.v
`timescale 1ns/1ps
`default_nettype none
`include "kwdt_map.vh"

module kwdt_tbdiv #(
  parameter [`KWDT_DIV_W-1:0] DIV = `KWDT_TICK_CYC
) (
  // Clock and reset
  input  wire                   pclk,
  input  wire                   presetn,
  // Divided tick
  output reg                    time_base_tap_256hz
);

  reg [`KWDT_DIV_W-1:0] phase_reg;

  // Free running: never restarted by a key, so a clear lands at any phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg           <= {`KWDT_DIV_W{1'b0}};
      time_base_tap_256hz <= 1'b0;
    end else if (phase_reg == DIV - 1'b1) begin
      phase_reg           <= {`KWDT_DIV_W{1'b0}};
      time_base_tap_256hz <= 1'b1;
    end else begin
      phase_reg           <= phase_reg + 1'b1;
      time_base_tap_256hz <= 1'b0;
    end
  end

endmodule // kwdt_tbdiv

`default_nettype wire

// >>> core/kwdt_key.v
`timescale 1ns/1ps
`default_nettype none
`include "kwdt_map.vh"

module kwdt_key (
  // Clock and reset
  input  wire                   pclk,
  input  wire                   presetn,
  // Key writes and overflow
  input  wire                   key_wr,
  input  wire [`KWDT_KEY_W-1:0] key_data,
  input  wire                   ovf,
  // Sequence state and results
  output reg                    key_ptr,
  output reg                    key_armed,
  output reg                    key_accept,
  output reg                    key_reject
);

  wire first_ok;
  wire second_ok;

  assign first_ok  = !key_ptr && (key_data == `KWDT_KEY_FIRST);
  assign second_ok = key_ptr && key_armed &&
                     (key_data == `KWDT_KEY_SECOND);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_ptr    <= 1'b0;
      key_armed  <= 1'b0;
      key_accept <= 1'b0;
      key_reject <= 1'b0;
    end else if (ovf) begin
      // Overflow wins over a write in the same cycle
      key_ptr    <= 1'b0;
      key_armed  <= 1'b0;
      key_accept <= 1'b0;
      key_reject <= key_wr;
    end else if (key_wr) begin
      key_ptr    <= ~key_ptr;
      key_armed  <= first_ok;
      key_accept <= second_ok;
      key_reject <= !(first_ok || second_ok);
    end else begin
      key_accept <= 1'b0;
      key_reject <= 1'b0;
    end
  end

endmodule // kwdt_key

`default_nettype wire

// >>> core/kwdt_top.v
`timescale 1ns/1ps
`default_nettype none
`include "kwdt_map.vh"


module kwdt_top #(
  parameter [`KWDT_DIV_W-1:0] TICK_DIV = `KWDT_TICK_CYC
) (
  // Clock and reset
  input  wire                   pclk,
  input  wire                   presetn,
  // APB slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [11:0]            paddr,
  input  wire [31:0]            pwdata,
  input  wire [3:0]             pstrb,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  // Watchdog outputs
  output reg                    guard_overflow_irq,
  output reg                    guard_running,
  // Maskable event interrupt
  output reg                    irq
);

  // Counter state
  reg  [`KWDT_CNT_W-1:0]     guard_counter;
  reg                        run_reg;

  // Interrupt state
  reg  [`KWDT_IRQ_W-1:0]     irq_stat_reg;
  wire [`KWDT_IRQ_W-1:0]     irq_stat_next;
  reg  [`KWDT_IRQ_W-1:0]     irq_mask_reg;
  reg  [`KWDT_IRQ_W-1:0]     irq_mask_next;
  wire [`KWDT_IRQ_W-1:0]     irq_event;

  // Diagnostic state
  reg  [`KWDT_OVF_CNT_W-1:0] ovf_cnt_reg;
  reg  [`KWDT_KEY_W-1:0]     last_key_reg;
  reg                        last_ptr_reg;

  // Bus decode
  wire                       bus_setup;
  wire                       bus_done;
  wire                       bus_wr;
  wire                       aligned;
  wire                       hit_key;
  wire                       hit_state;
  wire                       hit_stat;
  wire                       hit_mask;
  wire                       hit_ovf;
  wire                       hit_last;
  wire                       hit_any;
  wire                       lane0;
  reg  [31:0]                rd_mux;

  // Sub-block links
  wire                       time_base_tap_256hz;
  wire                       key_wr;
  wire                       key_ptr;
  wire                       key_armed;
  wire                       key_accept;
  wire                       key_reject;
  wire                       at_max;
  wire                       ovf_evt;

  assign bus_setup = psel && !penable;
  assign bus_done  = psel && penable && pready;
  assign bus_wr    = bus_done && pwrite;
  assign aligned   = (paddr[1:0] == 2'b00);
  assign lane0     = pstrb[0];

  assign hit_key   = aligned && (paddr == `KWDT_OFS_KEY);
  assign hit_state = aligned && (paddr == `KWDT_OFS_STATE);
  assign hit_stat  = aligned && (paddr == `KWDT_OFS_IRQ_STAT);
  assign hit_mask  = aligned && (paddr == `KWDT_OFS_IRQ_MASK);
  assign hit_ovf   = aligned && (paddr == `KWDT_OFS_OVF_CNT);
  assign hit_last  = aligned && (paddr == `KWDT_OFS_LAST_KEY);
  assign hit_any   = hit_key || hit_state || hit_stat ||
                     hit_mask || hit_ovf || hit_last;

  // Only the low byte lane carries the key nibble
  assign key_wr = bus_wr && hit_key && lane0;

  // Divider: 10 MHz down to the counting tick
  kwdt_tbdiv #(
    .DIV                 (TICK_DIV)
  ) u_time_base_divider (
    .pclk                (pclk),
    .presetn             (presetn),
    .time_base_tap_256hz (time_base_tap_256hz)
  );

  // Two-write key sequence and pointer
  kwdt_key u_key (
    .pclk       (pclk),
    .presetn    (presetn),
    .key_wr     (key_wr),
    .key_data   (pwdata[`KWDT_KEY_W-1:0]),
    .ovf        (ovf_evt),
    .key_ptr    (key_ptr),
    .key_armed  (key_armed),
    .key_accept (key_accept),
    .key_reject (key_reject)
  );

  // Overflow only on a real wrap; a clear in the same cycle wins
  assign at_max  = (guard_counter == `KWDT_CNT_MAX);
  assign ovf_evt = run_reg && time_base_tap_256hz && at_max &&
                   !key_accept;

  // The divider is never resynchronised to a clear, so the first
  // interval after it can lose up to one tick of the 512
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_counter <= `KWDT_RST_CNT;
      run_reg       <= 1'b0;
    end else if (key_accept) begin
      guard_counter <= `KWDT_RST_CNT;
      run_reg       <= 1'b1;
    end else if (run_reg && time_base_tap_256hz) begin
      // Wraps to zero and keeps going after overflow
      guard_counter <= guard_counter + 1'b1;
    end
  end

  // Events feeding the sticky status bits
  assign irq_event[`KWDT_IRQ_OVF]    = ovf_evt;
  assign irq_event[`KWDT_IRQ_REJECT] = key_reject;
  assign irq_event[`KWDT_IRQ_START]  = key_accept && !run_reg;
  assign irq_event[`KWDT_IRQ_CLEAR]  = key_accept && run_reg;

  // Write one to clear; an event in the same cycle keeps the bit set
  genvar gi;
  generate
    for (gi = 0; gi < `KWDT_IRQ_W; gi = gi + 1) begin : g_stat
      assign irq_stat_next[gi] = irq_event[gi] ||
        (irq_stat_reg[gi] &&
         !(bus_wr && hit_stat && lane0 && pwdata[gi]));
    end
  endgenerate

  always @* begin
    irq_mask_next = irq_mask_reg;
    if (bus_wr && hit_mask && lane0) begin
      irq_mask_next = pwdata[`KWDT_IRQ_W-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= {`KWDT_IRQ_W{1'b0}};
      irq_mask_reg <= `KWDT_RST_MASK;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Watchdog line ignores the mask entirely; it stays up until
  // software clears the overflow status bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_overflow_irq <= 1'b0;
      irq                <= 1'b0;
      guard_running      <= 1'b0;
    end else begin
      guard_overflow_irq <= irq_stat_next[`KWDT_IRQ_OVF];
      irq                <= |(irq_stat_next & irq_mask_next);
      guard_running      <= run_reg || key_accept;
    end
  end

  // Overflow tally saturates; a write with byte lane 0 clears it unless an
  // overflow lands in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_cnt_reg <= `KWDT_RST_OVF_CNT;
    end else if (ovf_evt) begin
      if (ovf_cnt_reg != `KWDT_OVF_CNT_MAX) begin
        ovf_cnt_reg <= ovf_cnt_reg + 1'b1;
      end
    end else if (bus_wr && hit_ovf && lane0) begin
      ovf_cnt_reg <= `KWDT_RST_OVF_CNT;
    end
  end

  // Last key written and the pointer it met, for post-mortem reads
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_key_reg <= {`KWDT_KEY_W{1'b0}};
      last_ptr_reg <= 1'b0;
    end else if (key_wr) begin
      last_key_reg <= pwdata[`KWDT_KEY_W-1:0];
      last_ptr_reg <= key_ptr;
    end
  end

  // Read mux; the key register reads as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit_state) begin
      rd_mux[`KWDT_ST_CNT_MSB:`KWDT_ST_CNT_LSB] = guard_counter;
      rd_mux[`KWDT_ST_RUN]   = run_reg;
      rd_mux[`KWDT_ST_PTR]   = key_ptr;
      rd_mux[`KWDT_ST_ARMED] = key_armed;
    end else if (hit_stat) begin
      rd_mux[`KWDT_IRQ_W-1:0] = irq_stat_reg;
    end else if (hit_mask) begin
      rd_mux[`KWDT_IRQ_W-1:0] = irq_mask_reg;
    end else if (hit_ovf) begin
      rd_mux[`KWDT_OVF_CNT_W-1:0] = ovf_cnt_reg;
    end else if (hit_last) begin
      rd_mux[`KWDT_KEY_W-1:0] = last_key_reg;
      rd_mux[`KWDT_KEY_W]     = last_ptr_reg;
    end
  end

  // One wait-free access phase: the answer is prepared in the setup
  // cycle so every bus output comes straight from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (bus_setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pready  <= 1'b1;
      pslverr <= !hit_any;
    end else begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // kwdt_top

`default_nettype wire

// >>> test/kwdt_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module kwdt_chk #(
  parameter [15:0] TICK_DIV = 16'h0004
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Watchdog
  input wire logic        guard_overflow_irq,
  input wire logic        guard_running,
  input wire logic        irq
);
  // One tick of slack for the asynchronous clear
  localparam int MIN_OVF = 511 * TICK_DIV - 2;
  logic        ka1, ka2, kc1, kc2, m_ptr, m_armed, ovf_q;
  logic [15:0] run_cyc;
  wire acc = psel & penable & pready & pwrite & pstrb[0];
  wire key_acc = acc && paddr == 12'h000;
  // Second key that really clears: 0A at pointer one after a good 5
  wire key_ok = key_acc && m_ptr && m_armed && pwdata[3:0] == 4'ha;
  wire ovf_rise = guard_overflow_irq && !ovf_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ka1 <= 1'b0;
      ka2 <= 1'b0;
      kc1 <= 1'b0;
      kc2 <= 1'b0;
      m_ptr <= 1'b0;
      m_armed <= 1'b0;
      ovf_q <= 1'b0;
      run_cyc <= 16'h0000;
    end else begin
      ka1 <= key_ok;
      ka2 <= ka1;
      kc1 <= acc && paddr == 12'h008 && pwdata[0];
      kc2 <= kc1;
      ovf_q <= guard_overflow_irq;
      // Pointer clear seen one edge late; an overflow under a
      // still-set request is not seen at all
      if (ovf_rise) begin
        m_ptr <= 1'b0;
        m_armed <= 1'b0;
      end else if (key_acc) begin
        m_ptr <= !m_ptr;
        m_armed <= !m_ptr && pwdata[3:0] == 4'h5;
      end
      // Interval restarts at start, at each accepted clear, at wrap
      if (!guard_running || ka1 || ovf_rise)
        run_cyc <= 16'h0000;
      else if (run_cyc != 16'hffff)
        run_cyc <= run_cyc + 16'h0001;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_start_key: assert property ($rose(guard_running) |-> ka1 || ka2)
    else $error("start without second key");
  a_run_holds: assert property (guard_running |=> guard_running)
    else $error("counter stopped");
  a_ovf_late: assert property ($rose(guard_overflow_irq) |->
    guard_running && run_cyc >= MIN_OVF)
    else $error("overflow too early");
  a_ovf_sticky: assert property ($fell(guard_overflow_irq) |-> kc1 || kc2)
    else $error("watchdog request dropped");
  cover property ($rose(guard_running));
  cover property ($rose(guard_overflow_irq));
  cover property (pslverr);
  cover property ($rose(irq));
  cover property (ka1);
endmodule // kwdt_chk
bind kwdt_top kwdt_chk #(.TICK_DIV(TICK_DIV)) kwdt_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .guard_overflow_irq(guard_overflow_irq),
  .guard_running(guard_running), .irq(irq));
`default_nettype wire

// >>> test/kwdt_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module kwdt_cpu (
  // Clock
  input wire logic         pclk,
  // APB answer
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  // APB request
  output var logic         psel,
  output var logic         penable,
  output var logic         pwrite,
  output var logic [11:0]  paddr,
  output var logic [31:0]  pwdata,
  output var logic [3:0]   pstrb
);
  int hangs = 0;
  // Byte strobes of the next transfer; the bench may drop lane 0
  logic [3:0] strb = 4'hf;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 16);
    if (!pready)
      hangs++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // Service routine: the two-write key sequence
  task automatic kick;
    logic [31:0] q;
    logic        e;
    xfer(1'b1, 12'h000, 32'h5, q, e);
    xfer(1'b1, 12'h000, 32'ha, q, e);
  endtask
endmodule // kwdt_cpu
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic        guard_overflow_irq, guard_running, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          n;
  always #50 pclk = ~pclk;
  kwdt_cpu kwdt_cpu_i (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  // Short tick keeps overflow at 2048 cycles
  kwdt_top #(.TICK_DIV(16'h0004)) kwdt_top_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .guard_overflow_irq(guard_overflow_irq),
    .guard_running(guard_running));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    kwdt_cpu_i.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    kwdt_cpu_i.xfer(1'b1, a, d, q, e);
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // A bus wait that ran out ends the run at once
  always @(posedge pclk) begin
    if (kwdt_cpu_i.hangs != 0) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h004); chk(q, 32'h0); chk(e, 0);
    rd(12'h00c); chk(q, 32'h0);
    rd(12'h010); chk(q, 32'h0);
    rd(12'h000); chk(q, 32'h0);
    rd(12'h020); chk(e, 1);
    rd(12'h006); chk(e, 1);
    kwdt_cpu_i.strb = 4'he;
    wr(12'h000, 32'h5); rd(12'h004); chk(q, 32'h0);
    kwdt_cpu_i.strb = 4'hf;
    wr(12'h000, 32'ha); rd(12'h004); chk(q, 32'h400);
    wr(12'h000, 32'h5); rd(12'h004); chk(q, 32'h0);
    wr(12'h000, 32'h3); wr(12'h000, 32'ha);
    rd(12'h004); chk(q, 32'h0);
    rd(12'h008); chk(q, 32'h2);
    wr(12'h00c, 32'h2); chk(irq, 1);
    wr(12'h008, 32'hf); chk(irq, 0);
    wr(12'h00c, 32'h0);
    wr(12'h000, 32'h5); rd(12'h004); chk(q, 32'hc00);
    wr(12'h000, 32'ha); chk(guard_running, 1);
    repeat (800) @(posedge pclk);
    rd(12'h004); chk(q[8:0] >= 9'h0c0, 1);
    kwdt_cpu_i.kick();
    rd(12'h004); chk(q[8:0] < 9'h004, 1);
    wr(12'h000, 32'h5); wr(12'h000, 32'h5); wr(12'h000, 32'ha);
    rd(12'h004); chk(q[11:9], 3'b011);
    rd(12'h014); chk(q, 32'ha);
    n = 0;
    while (!guard_overflow_irq && n < 2200) begin
      @(posedge pclk);
      n++;
    end
    chk(guard_overflow_irq, 1);
    chk(n > 1900 && n < 2100, 1);
    rd(12'h004); chk(q[11:9], 3'b001);
    chk(irq, 0);
    rd(12'h010); chk(q, 32'h1);
    wr(12'h010, 32'h0); rd(12'h010); chk(q, 32'h0);
    wr(12'h008, 32'h1); chk(guard_overflow_irq, 0);
    chk(kwdt_cpu_i.hangs, 0);
    stop_test();
  end
endmodule // tb
`default_nettype wire
